// *** ivt_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ivt_cpu_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // stacking handshake
  input wire logic trap_push,
  input wire logic [3:0] stack_dly,
  output logic stack_done
);
  logic [3:0] wait_r;

  // stack the pc after a chosen delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 4'h0;
      stack_done <= 1'h0;
    end else if (trap_push && !stack_done) begin
      wait_r <= wait_r + 4'h1;
      stack_done <= (wait_r >= stack_dly);
    end else begin
      wait_r <= 4'h0;
      stack_done <= 1'h0;
    end
  end
endmodule // ivt_cpu_model
`default_nettype wire

// *** ivt_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ivt_monitor
  import ivt_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // sources
  input wire logic ext_irq_level1,
  input wire logic fetch_valid,
  input wire logic ack0_mode0_fetch,
  input wire logic stack_done,
  input wire logic vec_req,
  input wire logic [VEC_LO_W-1:0] vec_src_code,
  // results
  input wire logic [REG_W-1:0] synth_vector,
  input wire logic synth_vector_valid,
  input wire logic [LVL_N-1:0] irq_level_req,
  input wire logic trap_req,
  input wire logic trap_push,
  input wire logic trap_restart,
  input wire logic [15:0] trap_restart_addr
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_VEC_LOW: assert property (
    vec_req |=> synth_vector_valid &&
      synth_vector[VEC_LO_W-1:0] == $past(vec_src_code))
    else $error("vector low bits wrong");
  AST_APB_ANS: assert property (psel && !penable |=> pready)
    else $error("no access answer");
  AST_APB_ERR: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  AST_TRAP_CAUSE: assert property (
    trap_req |-> $past(fetch_valid || ack0_mode0_fetch))
    else $error("trap without fetch");
  AST_TRAP_PUSH: assert property (
    trap_req |-> trap_push ##1 !trap_req)
    else $error("trap pulse or push wrong");
  AST_PUSH_HOLD: assert property (
    trap_push && !stack_done |=> trap_push)
    else $error("push dropped early");
  AST_RESTART: assert property (
    trap_push && stack_done |=> !trap_push && trap_restart ##1 !trap_restart)
    else $error("restart wrong after stacking");
  AST_RST_ADDR: assert property (
    trap_restart |-> trap_restart_addr == 16'h0000 && $past(trap_push))
    else $error("restart address wrong");
  AST_LVL1: assert property (
    irq_level_req[1] |-> $past(ext_irq_level1, 2) ||
      $past(ext_irq_level1, 3) || $past(ext_irq_level1, 4))
    else $error("level 1 without pin");
endmodule // ivt_monitor

bind ivt_trap_ctrl ivt_monitor u_mon (.*);
`default_nettype wire

// *** ivt_opcode_check.sv ***
`timescale 1ns/1ps
`default_nettype none
module ivt_opcode_check
  import ivt_pkg::*;
(
  // byte to classify and the prefix it follows
  input wire ivt_chk_kind_t kind,
  input wire logic [7:0] op,
  // high when the byte is not a defined opcode
  output logic undefined
);

  // second byte after the bit prefix: only the shift group 30-37 is missing
  function automatic logic undef_cb(logic [7:0] b);
    return (b[7:3] == 5'h06);
  endfunction

  // second byte after the extended prefix
  function automatic logic undef_ed(logic [7:0] b);
    logic r;
    r = 1'b1;
    if (b[7:6] == 2'h0) begin
      r = !((b[2:0] == 3'h0) || (b[2:0] == 3'h1) || (b[2:0] == 3'h4));
      if (b == 8'h30 || b == 8'h31) begin
        r = 1'b1;
      end
    end else if (b[7:6] == 2'h1) begin
      r = (b == 8'h4E) || (b == 8'h66) || (b == 8'h6E) ||
          (b == 8'h71) || (b == 8'h77) || (b == 8'h7F);
    end else if (b[7:6] == 2'h2) begin
      r = !((b[2] == 1'b0 && b[5] == 1'b1 && b[4:3] != 2'h3) ||
            (b[1:0] == 2'h3 && b[5] == 1'b0 && b[2] == 1'b0) ||
            (b[2:0] <= 3'h3 && b[5] == 1'b1));
    end
    return r;
  endfunction

  // second byte after an index prefix
  function automatic logic undef_idx(logic [7:0] b);
    logic r;
    r = 1'b1;
    case (b)
      8'h09, 8'h19, 8'h21, 8'h22, 8'h23, 8'h29, 8'h2A, 8'h2B,
      8'h34, 8'h35, 8'h36, 8'h39, 8'h46, 8'h4E, 8'h56, 8'h5E,
      8'h66, 8'h6E, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75,
      8'h77, 8'h7E, 8'h86, 8'h8E, 8'h96, 8'h9E, 8'hA6, 8'hAE,
      8'hB6, 8'hBE, 8'hCB, 8'hE1, 8'hE3, 8'hE5, 8'hE9, 8'hF9: begin
        r = 1'b0;
      end
      default: begin
        r = 1'b1;
      end
    endcase
    return r;
  endfunction

  // third byte after an indexed bit prefix
  function automatic logic undef_idxcb(logic [7:0] b);
    return (b[2:0] != 3'h6) || (b == 8'h36);
  endfunction

  always_comb begin
    case (kind)
      CK_CB: undefined = undef_cb(op);
      CK_ED: undefined = undef_ed(op);
      CK_IDX: undefined = undef_idx(op);
      CK_IDXCB: undefined = undef_idxcb(op);
      default: undefined = 1'b0;
    endcase
  end

endmodule // ivt_opcode_check
`default_nettype wire

// *** ivt_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ivt_pin_sync
  import ivt_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins in, synchronised levels out
  input wire logic [LVL_N-1:0] pin_in,
  output logic [LVL_N-1:0] pin_sync
);

  typedef struct packed {
    logic [LVL_N-1:0] s1;
    logic [LVL_N-1:0] s2;
  } ivt_sync_state_t;

  ivt_sync_state_t q_r;
  ivt_sync_state_t q_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // two stages per pin; only stage two is read outside
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = pin_in;
    q_nxt.s2 = q_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign pin_sync = q_r.s2;

endmodule // ivt_pin_sync
`default_nettype wire

// *** ivt_pkg.sv ***
package ivt_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_VEC_LOW = 8'h33;
  localparam logic [7:0] IDX_TRAP_CTL = 8'h34;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h41;

  function automatic logic [ADDR_W-1:0] ivt_byte_addr(logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // vector low register layout
  localparam int VEC_HI_LSB = 5;
  localparam int VEC_HI_W = 3;
  localparam int VEC_LO_W = 5;
  localparam logic [VEC_HI_W-1:0] VEC_HI_RST = 3'h0;

  // trap and level control register layout
  localparam int TRAP_FLAG_BIT = 7;
  localparam int FETCH_POS_BIT = 6;
  localparam int LVL_N = 3;
  localparam logic [LVL_N-1:0] LVL_EN_RST = 3'h1;
  localparam logic FETCH_POS_SECOND = 1'b0;
  localparam logic FETCH_POS_THIRD = 1'b1;

  // sticky status and mask layout
  localparam int ST_W = 4;
  localparam int ST_TRAP = 0;
  localparam int ST_LVL0 = 1;
  localparam logic [ST_W-1:0] ST_RST = 4'h0;

  // prefix opcodes
  localparam logic [7:0] PFX_CB = 8'hCB;
  localparam logic [7:0] PFX_DD = 8'hDD;
  localparam logic [7:0] PFX_ED = 8'hED;
  localparam logic [7:0] PFX_FD = 8'hFD;

  localparam logic [15:0] TRAP_RESTART_ADDR = 16'h0000;

  typedef enum logic [1:0] {
    CK_CB,
    CK_ED,
    CK_IDX,
    CK_IDXCB
  } ivt_chk_kind_t;

endpackage

// *** ivt_trap_ctrl.sv ***
// Notes on behaviour
// R1: vector bits 7-5 come from register
// R2: reset clears programmable vector bits
// R3: undefined opcode fetch sets trap flag
// R4: write zero clears flag, one ignored
// R5: reset clears trap flag
// R6: position bit: 0 second, 1 third
// R7: level2/level1 enables gate external inputs
// R8: level0 enable gates peripherals and input0
// R9: reset: level0 enabled, others disabled
// R10: trap ignores maskable interrupt enable flag
// R11: trap also during mode-0 acknowledge fetch
// R12: set flag first, then stack PC (flag and trap_push are set in the same cycle here)
// R13: after stacking, restart at address 0000h
// R14: check second byte after single prefix
// R15: check third byte after double prefix
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ivt_trap_ctrl
  import ivt_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt pins
  input wire logic ext_irq_level0,
  input wire logic ext_irq_level1,
  input wire logic ext_irq_level2,
  // on-chip level-0 sources
  input wire logic serial_ctrl_irq,
  input wire logic counter_timer_irq,
  input wire logic printer_irq,
  // cpu fetch stream
  input wire logic fetch_valid,
  input wire logic ack0_mode0_fetch,
  input wire logic [7:0] fetch_byte,
  input wire logic maskable_irq_enable_flag,
  input wire logic stack_done,
  // vector synthesis
  input wire logic vec_req,
  input wire logic [VEC_LO_W-1:0] vec_src_code,
  output logic [REG_W-1:0] synth_vector,
  output logic synth_vector_valid,
  // level requests to the cpu
  output logic [LVL_N-1:0] irq_level_req,
  // trap sequence to the cpu
  output logic trap_req,
  output logic trap_push,
  output logic trap_restart,
  output logic [15:0] trap_restart_addr,
  // interrupt output
  output logic irq
);

  typedef enum logic [2:0] {
    PX_NONE,
    PX_CB,
    PX_ED,
    PX_DD,
    PX_FD,
    PX_IDXCB
  } ivt_pfx_t;

  typedef enum logic [1:0] {
    TS_IDLE,
    TS_PUSH,
    TS_JUMP
  } ivt_trap_st_t;

  typedef struct packed {
    ivt_pfx_t pfx;
    ivt_trap_st_t tst;
    logic [VEC_HI_W-1:0] vec_hi;
    logic trap_flag;
    logic fetch_byte_position;
    logic [LVL_N-1:0] lvl_en;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] mask;
    logic [LVL_N-1:0] lvl_req;
    logic [REG_W-1:0] vec;
    logic vec_vld;
    logic trap_req;
    logic trap_push;
    logic trap_restart;
    logic [15:0] restart_addr;
    logic irq;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } ivt_state_t;

  ivt_state_t q_r;
  ivt_state_t q_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and opcode classifier

  logic [LVL_N-1:0] pins_sync;
  ivt_chk_kind_t chk_kind;
  logic op_undef;

  // pins reach the level gate two edges late
  ivt_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({ext_irq_level2, ext_irq_level1, ext_irq_level0}),
    .pin_sync(pins_sync)
  );

  ivt_opcode_check u_check (
    .kind(chk_kind),
    .op(fetch_byte),
    .undefined(op_undef)
  );

  // prefix state picks the table for the next byte
  always_comb begin
    case (q_r.pfx)
      PX_CB: chk_kind = CK_CB;
      PX_ED: chk_kind = CK_ED;
      PX_IDXCB: chk_kind = CK_IDXCB;
      default: chk_kind = CK_IDX;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic setup_ph;
  logic wr_acc;
  logic hit_vec;
  logic hit_trap;
  logic hit_stat;
  logic hit_mask;

  logic op_stb;
  logic trap_hit;

  logic [ST_W-1:0] events;
  logic [ST_W-1:0] w1c;
  logic [LVL_N-1:0] lvl_src;

  always_comb begin
    q_nxt = q_r;
    // a setup is new only while no answer stands
    setup_ph = psel && !penable && !q_r.pready;
    wr_acc = psel && penable && pwrite && q_r.pready;
    hit_vec = (paddr == ivt_byte_addr(IDX_VEC_LOW));
    hit_trap = (paddr == ivt_byte_addr(IDX_TRAP_CTL));
    hit_stat = (paddr == ivt_byte_addr(IDX_IRQ_STAT));
    hit_mask = (paddr == ivt_byte_addr(IDX_IRQ_MASK));
    // opcode bytes of normal fetches and of mode-0 acknowledge
    // refused while the trap sequence runs
    op_stb = (fetch_valid || ack0_mode0_fetch) && // see R11
             (q_r.tst == TS_IDLE);
    trap_hit = 1'b0;
    events = '0;
    w1c = '0;

    // prefix tracking and trap detection, not gated by the
    // maskable enable flag
    // displacement bytes are never strobed in
    if (op_stb) begin // see R10
      case (q_r.pfx)
        PX_NONE: begin
          if (fetch_byte == PFX_CB) begin
            q_nxt.pfx = PX_CB;
          end else if (fetch_byte == PFX_ED) begin
            q_nxt.pfx = PX_ED;
          end else if (fetch_byte == PFX_DD) begin
            q_nxt.pfx = PX_DD;
          end else if (fetch_byte == PFX_FD) begin
            q_nxt.pfx = PX_FD;
          end
        end
        PX_CB, PX_ED: begin
          trap_hit = op_undef; // see R14
          q_nxt.fetch_byte_position = op_undef ?
            FETCH_POS_SECOND : q_r.fetch_byte_position; // see R6
          q_nxt.pfx = PX_NONE;
        end
        PX_DD, PX_FD: begin
          if (fetch_byte == PFX_CB) begin
            q_nxt.pfx = PX_IDXCB;
          end else begin
            trap_hit = op_undef; // see R14
            q_nxt.fetch_byte_position = op_undef ?
              FETCH_POS_SECOND : q_r.fetch_byte_position; // see R6
            q_nxt.pfx = PX_NONE;
          end
        end
        PX_IDXCB: begin
          trap_hit = op_undef; // see R15
          q_nxt.fetch_byte_position = op_undef ?
            FETCH_POS_THIRD : q_r.fetch_byte_position; // see R6
          q_nxt.pfx = PX_NONE;
        end
        default: begin
          q_nxt.pfx = PX_NONE;
        end
      endcase
    end

    // trap sequence: flag and push in the same cycle, then restart
    q_nxt.trap_req = 1'b0;
    q_nxt.trap_restart = 1'b0;
    case (q_r.tst)
      TS_IDLE: begin
        if (trap_hit) begin
          q_nxt.trap_req = 1'b1;
          q_nxt.trap_push = 1'b1; // see R12
          q_nxt.tst = TS_PUSH;
        end
      end
      TS_PUSH: begin
        if (stack_done) begin
          q_nxt.trap_push = 1'b0;
          q_nxt.trap_restart = 1'b1; // see R13
          q_nxt.restart_addr = TRAP_RESTART_ADDR; // see R13
          q_nxt.tst = TS_JUMP;
        end
      end
      TS_JUMP: begin
        // one cycle of jump, then bytes are taken again
        q_nxt.tst = TS_IDLE;
      end
      default: begin
        q_nxt.trap_push = 1'b0;
        q_nxt.tst = TS_IDLE;
      end
    endcase

    // flag: a set in the same cycle beats a software clear
    q_nxt.trap_flag = (q_r.trap_flag &&
      !(wr_acc && hit_trap && !pwdata[TRAP_FLAG_BIT])) || // see R4
      trap_hit; // see R3

    // register writes; flag and position handled above
    if (wr_acc && hit_vec) begin
      q_nxt.vec_hi = pwdata[VEC_HI_LSB +: VEC_HI_W];
    end

    if (wr_acc && hit_trap) begin
      q_nxt.lvl_en = pwdata[LVL_N-1:0];
    end

    if (wr_acc && hit_mask) begin
      q_nxt.mask = pwdata[ST_W-1:0];
    end

    if (wr_acc && hit_stat) begin
      w1c = pwdata[ST_W-1:0];
    end

    // level gating; level 0 merges pin 0 with on-chip sources
    // on-chip sources share the clock; no sync needed
    lvl_src = pins_sync;
    lvl_src[0] = pins_sync[0] || serial_ctrl_irq ||
                 counter_timer_irq || printer_irq; // see R8
    q_nxt.lvl_req = lvl_src & q_r.lvl_en; // see R7

    // vector: programmable upper bits over the source code
    // valid copies the request, one cycle behind it
    q_nxt.vec_vld = vec_req;
    if (vec_req) begin
      q_nxt.vec = {q_r.vec_hi, vec_src_code}; // see R1
    end

    // sticky events; set beats write-one clear
    // rising edges only, so a held source sets once
    events[ST_TRAP] = trap_hit;
    events[ST_LVL0 +: LVL_N] = q_nxt.lvl_req & ~q_r.lvl_req;
    q_nxt.stat = (q_r.stat & ~w1c) | events;
    q_nxt.irq = |(q_nxt.stat & q_nxt.mask);

    // apb: answer in the cycle after setup
    // unmapped: error with ready, zero data, write dropped
    q_nxt.pready = setup_ph;
    q_nxt.pslverr = 1'b0;
    if (setup_ph) begin
      q_nxt.pslverr = !(hit_vec || hit_trap || hit_stat || hit_mask);
      q_nxt.prdata = '0;
      if (hit_vec) begin
        q_nxt.prdata[VEC_HI_LSB +: VEC_HI_W] = q_r.vec_hi;
      end else if (hit_trap) begin
        q_nxt.prdata[TRAP_FLAG_BIT] = q_r.trap_flag;
        q_nxt.prdata[FETCH_POS_BIT] = q_r.fetch_byte_position;
        q_nxt.prdata[LVL_N-1:0] = q_r.lvl_en;
      end else if (hit_stat) begin
        q_nxt.prdata[ST_W-1:0] = q_r.stat;
      end else if (hit_mask) begin
        q_nxt.prdata[ST_W-1:0] = q_r.mask;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  // named reset values laid over the zero fill

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
      q_r.pfx <= PX_NONE;
      q_r.tst <= TS_IDLE;
      q_r.vec_hi <= VEC_HI_RST; // see R2
      q_r.trap_flag <= 1'b0; // see R5
      q_r.fetch_byte_position <= FETCH_POS_SECOND;
      q_r.lvl_en <= LVL_EN_RST; // see R9
      q_r.stat <= ST_RST;
      q_r.mask <= ST_RST;
      q_r.restart_addr <= TRAP_RESTART_ADDR; // see R13
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // each one straight from the state register

  assign prdata = q_r.prdata;
  assign pready = q_r.pready;
  assign pslverr = q_r.pslverr;
  assign synth_vector = q_r.vec;
  assign synth_vector_valid = q_r.vec_vld;
  assign irq_level_req = q_r.lvl_req;
  assign trap_req = q_r.trap_req;
  assign trap_push = q_r.trap_push;
  assign trap_restart = q_r.trap_restart;
  assign trap_restart_addr = q_r.restart_addr;
  assign irq = q_r.irq;

endmodule // ivt_trap_ctrl
`default_nettype wire

// *** ivt_trap_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ivt_trap_ctrl_tb_top
  import ivt_pkg::*;
;
  localparam logic [11:0] A_VEC = 12'h0CC;
  localparam logic [11:0] A_CTL = 12'h0D0;
  localparam logic [11:0] A_STA = 12'h100;
  localparam logic [11:0] A_MSK = 12'h104;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic [ADDR_W-1:0] paddr = 12'h0;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, synth_vector_valid;
  logic trap_req, trap_push, trap_restart, stack_done;
  logic ext_irq_level0 = 1'h0, ext_irq_level1 = 1'h0, ext_irq_level2 = 1'h0;
  logic serial_ctrl_irq = 1'h0, counter_timer_irq = 1'h0, printer_irq = 1'h0;
  logic fetch_valid = 1'h0, ack0_mode0_fetch = 1'h0, vec_req = 1'h0;
  logic maskable_irq_enable_flag = 1'h0;
  logic [7:0] fetch_byte = 8'h0;
  logic [VEC_LO_W-1:0] vec_src_code = 5'h0;
  logic [REG_W-1:0] synth_vector;
  logic [LVL_N-1:0] irq_level_req;
  logic [15:0] trap_restart_addr;
  logic [3:0] stack_dly = 4'h0;
  logic [31:0] lfsr = 32'h1BA7;
  // ak, irq flag, trap, third byte, prefix, middle, last
  logic [27:0] tc [8] = '{28'h0CB0000, 28'h2CB0030, 28'h7DDCB30,
    28'h7FDCB30, 28'hACB0030, 28'h6ED00FF, 28'h2DD00ED, 28'h2FD00FD};
  int err_total = 0, cmp_count = 0, cyc = 0;

  ivt_trap_ctrl DUT (.*);
  ivt_cpu_model u_cpu (.*);

  always #5 pclk = ~pclk;

  ////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] exp_ctl(input logic f, input logic p);
    return {24'h0, f, f & p, 6'h07};
  endfunction

  // sources 0-2 are the pins, 3-5 the on-chip level-0 group
  function automatic logic [31:0] lvl_bit(input int i);
    return (i < 3) ? (32'h1 << i) : 32'h1;
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, got);
    cmp_count++;
    if (got !== ex) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic src(input logic [5:0] v);
    @(posedge pclk);
    {printer_irq, counter_timer_irq, serial_ctrl_irq} <= v[5:3];
    {ext_irq_level2, ext_irq_level1, ext_irq_level0} <= v[2:0];
  endtask

  task automatic op(input logic ak, input logic [7:0] b);
    @(posedge pclk);
    fetch_valid <= !ak;
    ack0_mode0_fetch <= ak;
    fetch_byte <= b;
  endtask

  task automatic tseq(input logic [27:0] t);
    int n;
    op(t[27], t[23:16]);
    if (t[15:8] !== 8'h00) op(t[27], t[15:8]);
    op(t[27], t[7:0]);
    @(posedge pclk);
    fetch_valid <= 1'h0;
    ack0_mode0_fetch <= 1'h0;
    @(negedge pclk);
    chk("trap_req", {31'h0, t[25]}, {31'h0, trap_req});
    n = 0;
    while (t[25] && trap_restart !== 1'h1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    if (t[25]) chk("restart", 32'h10000, {trap_restart, trap_restart_addr});
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, A_VEC, 32'h0);
    chk("vec_rst", 32'h0, rd & 32'hFFFFFFE0);
    apb(1'h0, A_CTL, 32'h0);
    chk("ctl_rst", 32'h1, rd);
    apb(1'h0, 12'h200, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      apb(1'h1, A_VEC, lfsr);
      apb(1'h0, A_VEC, 32'h0);
      chk("vec_low", {24'h0, lfsr[7:5], 5'h0}, rd & 32'hFFFFFFE0);
      @(posedge pclk);
      vec_req <= 1'h1;
      vec_src_code <= lfsr[12:8];
      @(posedge pclk);
      vec_req <= 1'h0;
      @(negedge pclk);
      chk("vector", {23'h0, 1'h1, lfsr[7:5], lfsr[12:8]}, {synth_vector_valid, synth_vector});
    end
    apb(1'h1, A_MSK, 32'hE);
    for (int i = 0; i < 6; i++) begin
      for (int e = 0; e < 2; e++) begin
        apb(1'h1, A_CTL, e ? lvl_bit(i) : 32'h0);
        apb(1'h1, A_STA, 32'hF);
        src(6'h1 << i);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk("level", e ? lvl_bit(i) : 32'h0, {29'h0, irq_level_req});
        chk("lvl_irq", {31'h0, e[0]}, {31'h0, irq});
        apb(1'h0, A_STA, 32'h0);
        chk("lvl_stat", e ? lvl_bit(i) << 1 : 32'h0, rd);
        src(6'h0);
      end
    end
    foreach (tc[i]) begin
      lfsr = nxt(lfsr);
      apb(1'h1, A_CTL, 32'h7);
      maskable_irq_enable_flag <= tc[i][26];
      stack_dly <= lfsr[3:0];
      apb(1'h1, A_STA, 32'hF);
      apb(1'h1, A_MSK, {31'h0, lfsr[4]});
      apb(1'h0, A_CTL, 32'h0);
      chk("ctl_clr", 32'h7, rd & ~32'h40);
      chk("irq_clr", 32'h0, {31'h0, irq});
      tseq(tc[i]);
      apb(1'h0, A_CTL, 32'h0);
      chk("ctl_trap", exp_ctl(tc[i][25], tc[i][24]), rd);
      chk("irq", {31'h0, tc[i][25] & lfsr[4]}, {31'h0, irq});
      apb(1'h1, A_CTL, 32'hFF);
      apb(1'h0, A_CTL, 32'h0);
      chk("ctl_w1", exp_ctl(tc[i][25], tc[i][24]), rd);
    end
    report_and_stop();
  end
endmodule // ivt_trap_ctrl_tb_top
`default_nettype wire
